// ---- src/adc_ctrl_pkg.sv ----
// Shared constants for the converter reset and power-down control block.
// Assumes a single 125 MHz system clock and a host on the serial configuration pins.
`default_nettype none

package adc_ctrl_pkg;
   localparam int ADDR_W  = 8;
   localparam int DATA_W  = 16;
   localparam int FRAME_W = ADDR_W + DATA_W;
   localparam int CHANNELS = 8;
   localparam int GAIN_W   = 4;
   localparam int DRIVE_W  = 3;
   localparam int PHASE_W  = 2;

   localparam logic [ADDR_W-1:0] ADDR_SOFT_RESET = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_POWER      = 8'h0f;
   localparam logic [ADDR_W-1:0] ADDR_LVDS_DRIVE = 8'h11;
   localparam logic [ADDR_W-1:0] ADDR_NOISE      = 8'h14;
   localparam logic [ADDR_W-1:0] ADDR_INVERT     = 8'h24;
   localparam logic [ADDR_W-1:0] ADDR_GAIN_LO    = 8'h2a;
   localparam logic [ADDR_W-1:0] ADDR_GAIN_HI    = 8'h2b;
   localparam logic [ADDR_W-1:0] ADDR_CLOCKING   = 8'h42;
   localparam logic [ADDR_W-1:0] ADDR_FORMAT     = 8'h46;

   localparam logic [DATA_W-1:0] REG_DEFAULT = 16'h0000;

   localparam int SOFT_RESET_BIT = 0;
   localparam int LIGHT_BIT      = 8;
   localparam int DEEP_BIT       = 9;
   localparam int PIN_CFG_BIT    = 10;
   localparam int CLK_DIFF_BIT   = 0;
   localparam int DCC_BIT        = 2;
   localparam int EXT_REF_BIT    = 3;
   localparam int PHASE_LSB      = 5;
   localparam int BTC_BIT        = 2;
   localparam int MSB_FIRST_BIT  = 3;
   localparam int SDR_BIT        = 4;
   localparam int SDR_FALL_BIT   = 13;
   localparam int DRV_CLK_LSB    = 0;
   localparam int DRV_FRAME_LSB  = 4;
   localparam int DRV_DATA_LSB   = 8;

   localparam int CLOCK_MHZ          = 125;
   localparam int CLOCK_WARM_TIME_US = 50;
   localparam int CLOCK_WARM_CYCLES  = CLOCK_WARM_TIME_US * CLOCK_MHZ;

   typedef enum {ST_AWAKE, ST_LIGHT, ST_DEEP, ST_WAKING} power_state_type;
endpackage

`default_nettype wire

// ---- src/pin_sync.sv ----
// Two-stage synchroniser for pins arriving from outside the system clock domain.
// Assumes nothing but a free-running clock; stage one feeds stage two only.
`default_nettype none

module pin_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] pin_async,
   output var  logic [WIDTH-1:0] pin_level
);
   logic [WIDTH-1:0] stage_one;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         stage_one <= '0;
         pin_level <= '0;
      end else begin
         stage_one <= pin_async;
         pin_level <= stage_one;
      end
   end
endmodule

`default_nettype wire

// ---- src/serial_write_port.sv ----
// Shift-in side of the serial configuration port: 8 address bits then 16 data bits.
// Assumes enable, clock and data were already synchronised to clk_sys.
`default_nettype none

module serial_write_port
   import adc_ctrl_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              rst,
   input  wire logic              enable_n_level,
   input  wire logic              shift_clk_level,
   input  wire logic              data_level,
   output var  logic              wr_strobe,
   output var  logic [ADDR_W-1:0] wr_addr,
   output var  logic [DATA_W-1:0] wr_data
);
   logic               shift_clk_prev;
   logic [FRAME_W-2:0] shifter;
   logic [4:0]         bit_count;
   logic               rise;

   assign rise = shift_clk_level & ~shift_clk_prev;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         shift_clk_prev <= 1'b0;
         shifter        <= '0;
         bit_count      <= '0;
         wr_strobe      <= 1'b0;
         wr_addr        <= '0;
         wr_data        <= '0;
      end else begin
         shift_clk_prev <= shift_clk_level;
         wr_strobe      <= 1'b0;
         // A frame dropped midway leaves nothing behind
         if (enable_n_level) begin
            bit_count <= '0;
         end else if (rise) begin
            shifter <= {shifter[FRAME_W-3:0], data_level};
            if (bit_count == 5'(FRAME_W - 1)) begin
               bit_count <= '0;
               wr_strobe <= 1'b1;
               {wr_addr, wr_data} <= {shifter, data_level};
            end else begin
               bit_count <= bit_count + 5'd1;
            end
         end
      end
   end
endmodule

`default_nettype wire

// ---- src/adc_reset_powerdown_control.sv ----
// Register file, software reset and power-down sequencing of the octal converter.
// Assumes the host writes over the serial pins and may drive the sleep pin freely.
`default_nettype none

module adc_reset_powerdown_control
   import adc_ctrl_pkg::*;
#(
   parameter logic [15:0] CLOCK_WARM      = 16'(CLOCK_WARM_CYCLES),
   parameter logic [15:0] LIGHT_WAKE_TIME = 16'h0010,
   parameter logic [15:0] DEEP_WAKE_TIME  = 16'h0400
) (
   input  wire logic                       clk_sys,
   input  wire logic                       rst,
   input  wire logic                       sen_n,
   input  wire logic                       sclk,
   input  wire logic                       sdata,
   input  wire logic                       sleep_pin,
   output var  logic                       sw_reset_pulse,
   output var  logic [CHANNELS-1:0]        channel_sleep_mask,
   output var  logic                       global_light_sleep,
   output var  logic                       global_deep_sleep,
   output var  logic                       converter_ready,
   output var  logic                       common_mode_pin_ref,
   output var  logic                       duty_cycle_corrector,
   output var  logic                       diff_clock_select,
   output var  logic [PHASE_W-1:0]         bit_clock_output_phase,
   output var  logic [CHANNELS-1:0]        noise_suppress,
   output var  logic [CHANNELS-1:0]        input_invert,
   output var  logic [CHANNELS*GAIN_W-1:0] channel_gain,
   output var  logic                       twos_complement_format,
   output var  logic                       msb_first,
   output var  logic                       single_rate,
   output var  logic                       single_rate_fall,
   output var  logic [DRIVE_W-1:0]         drive_bit_clock,
   output var  logic [DRIVE_W-1:0]         drive_frame_clock,
   output var  logic [DRIVE_W-1:0]         drive_data
);
   logic [3:0]        pins_level;
   logic              wr_strobe;
   logic [ADDR_W-1:0] wr_addr;
   logic [DATA_W-1:0] wr_data;
   logic              sw_reset;
   logic              pin_high;
   logic              deep_req;
   logic              light_req;

   logic [DATA_W-1:0] power_ctrl;
   logic [DATA_W-1:0] drive_ctrl;
   logic [DATA_W-1:0] noise_ctrl;
   logic [DATA_W-1:0] invert_ctrl;
   logic [DATA_W-1:0] gain_lo;
   logic [DATA_W-1:0] gain_hi;
   logic [DATA_W-1:0] clocking_ctrl;
   logic [DATA_W-1:0] format_ctrl;

   power_state_type   state;
   power_state_type   next_state;
   logic [15:0]       wake_count;
   logic [15:0]       next_wake_count;
   logic [15:0]       warm_count;
   logic              clock_warm;

   pin_sync #(
      .WIDTH(4)
   ) u_pin_sync (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .pin_async({sleep_pin, sdata, sclk, sen_n}),
      .pin_level(pins_level)
   );

   serial_write_port u_serial (
      .clk_sys        (clk_sys),
      .rst            (rst),
      .enable_n_level (pins_level[0]),
      .shift_clk_level(pins_level[1]),
      .data_level     (pins_level[2]),
      .wr_strobe      (wr_strobe),
      .wr_addr        (wr_addr),
      .wr_data        (wr_data)
   );

   assign pin_high = pins_level[3];
   assign sw_reset = wr_strobe && wr_addr == ADDR_SOFT_RESET && wr_data[SOFT_RESET_BIT];

   // Whole-word stores: a register is only ever replaced entirely
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         power_ctrl    <= REG_DEFAULT;
         drive_ctrl    <= REG_DEFAULT;
         noise_ctrl    <= REG_DEFAULT;
         invert_ctrl   <= REG_DEFAULT;
         gain_lo       <= REG_DEFAULT;
         gain_hi       <= REG_DEFAULT;
         clocking_ctrl <= REG_DEFAULT;
         format_ctrl   <= REG_DEFAULT;
      end else if (sw_reset) begin
         power_ctrl    <= REG_DEFAULT;
         drive_ctrl    <= REG_DEFAULT;
         noise_ctrl    <= REG_DEFAULT;
         invert_ctrl   <= REG_DEFAULT;
         gain_lo       <= REG_DEFAULT;
         gain_hi       <= REG_DEFAULT;
         clocking_ctrl <= REG_DEFAULT;
         format_ctrl   <= REG_DEFAULT;
      end else if (wr_strobe) begin
         case (wr_addr)
            ADDR_POWER:      power_ctrl    <= wr_data;
            ADDR_LVDS_DRIVE: drive_ctrl    <= wr_data;
            ADDR_NOISE:      noise_ctrl    <= wr_data;
            ADDR_INVERT:     invert_ctrl   <= wr_data;
            ADDR_GAIN_LO:    gain_lo       <= wr_data;
            ADDR_GAIN_HI:    gain_hi       <= wr_data;
            ADDR_CLOCKING:   clocking_ctrl <= wr_data;
            ADDR_FORMAT:     format_ctrl   <= wr_data;
            default: ;
         endcase
      end
   end

   // The reset bit is never stored; writing it restores every register's default and raises sw_reset_pulse for one cycle, one clock later
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sw_reset_pulse <= 1'b0;
      end else begin
         sw_reset_pulse <= sw_reset;
      end
   end

   assign common_mode_pin_ref    = clocking_ctrl[EXT_REF_BIT];
   assign duty_cycle_corrector   = clocking_ctrl[DCC_BIT];
   assign diff_clock_select      = clocking_ctrl[CLK_DIFF_BIT];
   assign bit_clock_output_phase = clocking_ctrl[PHASE_LSB +: PHASE_W];
   assign noise_suppress         = noise_ctrl[CHANNELS-1:0];
   assign input_invert           = invert_ctrl[CHANNELS-1:0];
   // Upper register lists channels five to eight from the top nibble down
   assign channel_gain = {gain_hi[3:0], gain_hi[7:4], gain_hi[11:8], gain_hi[15:12], gain_lo};
   assign twos_complement_format = format_ctrl[BTC_BIT];
   assign msb_first              = format_ctrl[MSB_FIRST_BIT];
   assign single_rate            = format_ctrl[SDR_BIT];
   assign single_rate_fall       = format_ctrl[SDR_FALL_BIT];
   assign drive_bit_clock        = drive_ctrl[DRV_CLK_LSB +: DRIVE_W];
   assign drive_frame_clock      = drive_ctrl[DRV_FRAME_LSB +: DRIVE_W];
   assign drive_data             = drive_ctrl[DRV_DATA_LSB +: DRIVE_W];

   // Deep wins when both are asked for, which happens if the host sets both sleep bits or sets one alongside a sleep pin routed to the other
   assign deep_req  = power_ctrl[DEEP_BIT] | (pin_high & ~power_ctrl[PIN_CFG_BIT]);
   assign light_req = power_ctrl[LIGHT_BIT] | (pin_high & power_ctrl[PIN_CFG_BIT]);

   // Quick light-sleep recovery needs the clock to have run long enough first
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         warm_count <= '0;
         clock_warm <= 1'b0;
      end else if (warm_count < CLOCK_WARM) begin
         warm_count <= warm_count + 16'd1;
      end else begin
         clock_warm <= 1'b1;
      end
   end

   always_comb begin
      next_state      = state;
      next_wake_count = wake_count;
      case (state)
         ST_AWAKE: begin
            if (deep_req) begin
               next_state = ST_DEEP;
            end else if (light_req) begin
               next_state = ST_LIGHT;
            end
         end
         ST_LIGHT: begin
            if (deep_req) begin
               next_state = ST_DEEP;
            end else if (!light_req) begin
               next_state      = ST_WAKING;
               next_wake_count = clock_warm ? LIGHT_WAKE_TIME : DEEP_WAKE_TIME;
            end
         end
         ST_DEEP: begin
            if (!deep_req) begin
               next_state      = light_req ? ST_LIGHT : ST_WAKING;
               next_wake_count = DEEP_WAKE_TIME;
            end
         end
         ST_WAKING: begin
            if (deep_req) begin
               next_state = ST_DEEP;
            end else if (light_req) begin
               next_state = ST_LIGHT;
            end else if (wake_count <= 16'd1) begin
               next_state = ST_AWAKE;
            end else begin
               next_wake_count = wake_count - 16'd1;
            end
         end
         default: next_state = ST_AWAKE;
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state      <= ST_AWAKE;
         wake_count <= '0;
      end else begin
         state      <= next_state;
         wake_count <= next_wake_count;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         channel_sleep_mask <= '0;
         global_light_sleep <= 1'b0;
         global_deep_sleep  <= 1'b0;
         converter_ready    <= 1'b1;
      end else begin
         channel_sleep_mask <= power_ctrl[CHANNELS-1:0] | {CHANNELS{next_state != ST_AWAKE}};
         global_light_sleep <= next_state == ST_LIGHT;
         global_deep_sleep  <= next_state == ST_DEEP;
         converter_ready    <= next_state == ST_AWAKE;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence soft_reset_write_s;
      sw_reset;
   endsequence

   sequence defaults_back_s;
      power_ctrl == REG_DEFAULT && clocking_ctrl == REG_DEFAULT && sw_reset_pulse;
   endsequence

   soft_reset_clear_a: assert property (soft_reset_write_s |=> defaults_back_s ##1 !sw_reset_pulse || sw_reset)
      else $error("soft reset did not restore defaults or pulse once");
   channel_sleep_a: assert property (##1 !power_ctrl[0] ##1 (state == ST_AWAKE) |-> !channel_sleep_mask[0] || $past(power_ctrl[0]))
      else $error("channel zero asleep without its mask bit");
   mask_sleep_a: assert property (power_ctrl[3] |=> channel_sleep_mask[3])
      else $error("masked channel three not asleep");
   light_enter_a: assert property (state == ST_AWAKE && light_req && !deep_req |=> state == ST_LIGHT ##0 global_light_sleep)
      else $error("light sleep request not entered");
   deep_enter_a: assert property (deep_req |=> state == ST_DEEP && global_deep_sleep && !converter_ready)
      else $error("deep sleep request not entered");
   deep_wake_a: assert property (state == ST_DEEP && !deep_req && !light_req |=> state == ST_WAKING && wake_count == DEEP_WAKE_TIME)
      else $error("deep sleep exit without long recovery");
   light_wake_a: assert property (state == ST_LIGHT && !light_req && !deep_req && clock_warm |=> wake_count == LIGHT_WAKE_TIME)
      else $error("warm light sleep exit without quick recovery");
   pin_deep_a: assert property (pin_high && !power_ctrl[PIN_CFG_BIT] |=> global_deep_sleep)
      else $error("sleep pin did not force deep sleep");
   pin_light_a: assert property (pin_high && power_ctrl[PIN_CFG_BIT] && !power_ctrl[DEEP_BIT] |=> global_light_sleep)
      else $error("sleep pin did not force light sleep");
   clock_defaults_a: assert property (sw_reset |=> !duty_cycle_corrector && !diff_clock_select && !common_mode_pin_ref)
      else $error("clocking options not back to defaults");
   noise_default_a: assert property (sw_reset |=> noise_suppress == '0 && input_invert == '0)
      else $error("noise suppression or input swap not off after reset");
   gain_default_a: assert property (sw_reset |=> channel_gain == '0)
      else $error("gain not 0 dB after reset");
   format_default_a: assert property (sw_reset |=> !twos_complement_format && !msb_first && !single_rate)
      else $error("output format not at defaults after reset");
   drive_default_a: assert property (sw_reset |=> drive_bit_clock == '0 && drive_data == '0)
      else $error("driver current not at default code after reset");

   sequence light_release_s;
      state == ST_LIGHT && !light_req && !deep_req;
   endsequence

   light_exit_a: assert property (light_release_s |=> state == ST_WAKING && !global_light_sleep)
      else $error("light sleep release did not start waking");
   cold_light_a: assert property (light_release_s ##0 !clock_warm |=> wake_count == DEEP_WAKE_TIME)
      else $error("cold light sleep exit took the quick recovery");
   warm_hold_a: assert property (clock_warm |=> clock_warm)
      else $error("clock warm flag dropped");
   deep_priority_a: assert property (deep_req && light_req |=> global_deep_sleep && !global_light_sleep)
      else $error("deep sleep did not win over light sleep");
   wake_done_a: assert property (state == ST_WAKING && wake_count <= 16'd1 && !deep_req && !light_req
      |=> converter_ready && channel_sleep_mask == $past(power_ctrl[CHANNELS-1:0]))
      else $error("waking did not end in ready with the channel mask");
   timing_defaults_a: assert property (sw_reset |=> !single_rate_fall && bit_clock_output_phase == '0)
      else $error("output timing options not at defaults after reset");
endmodule

`default_nettype wire

// ---- verification/host_serial_model.sv ----
// Host controller model: writes registers over the serial pins and drives the sleep pin.
// Assumes the caller starts frames only after reset release; one clk_sys domain.
`default_nettype none

module host_serial_model (
   input  wire logic clk_sys,
   output var  logic sen_n,
   output var  logic sclk,
   output var  logic sdata,
   output var  logic sleep_pin
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      sen_n     = 1'b1;
      sclk      = 1'b0;
      sdata     = 1'b0;
      sleep_pin = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   // One frame carries the whole register, so shared fields never see a half update
   task automatic write_reg(input logic [7:0] addr, input logic [15:0] data);
      logic [23:0] frame;
      frame = {addr, data};
      tick(1);
      sen_n = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         sdata = frame[i];
         tick(2);
         sclk = 1'b1;
         tick(4);
         sclk = 1'b0;
         tick(2);
      end
      tick(2);
      sen_n = 1'b1;
      // Released data line does not keep its last level
      sdata = ~sdata;
      tick(4);
   endtask

   task automatic set_pin(input logic v);
      tick(1);
      sleep_pin = v;
   endtask
endmodule

`default_nettype wire

// ---- verification/adc_reset_powerdown_control_test.sv ----
// Self-checking bench for the reset and power-down control block.
// Assumes the host model in its own file; shortened warm and wake counts.
`default_nettype none

module adc_reset_powerdown_control_test;
   import adc_ctrl_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int WARM  = 20;
   localparam int LIGHT = 4;
   localparam int DEEP  = 16;

   logic clk_sys, rst, sen_n, sclk, sdata, sleep_pin, sw_reset_pulse;
   logic global_light_sleep, global_deep_sleep, converter_ready;
   logic common_mode_pin_ref, duty_cycle_corrector, diff_clock_select, twos_complement_format;
   logic msb_first, single_rate, single_rate_fall;
   logic [7:0]  channel_sleep_mask, noise_suppress, input_invert;
   logic [1:0]  bit_clock_output_phase;
   logic [31:0] channel_gain;
   logic [2:0]  drive_bit_clock, drive_frame_clock, drive_data;
   logic [76:0] snap, got_val;
   logic [15:0] r0f, r11, r14, r24, r2a, r2b, r42, r46;
   logic [76:0] notes[$];
   int n_fail, checks, pulses, wake_n;
   event got_ev;

   adc_reset_powerdown_control #(.CLOCK_WARM(16'(WARM)), .LIGHT_WAKE_TIME(16'(LIGHT)),
      .DEEP_WAKE_TIME(16'(DEEP))) dut (.clk_sys(clk_sys), .rst(rst), .sen_n(sen_n), .sclk(sclk),
      .sdata(sdata), .sleep_pin(sleep_pin), .sw_reset_pulse(sw_reset_pulse),
      .channel_sleep_mask(channel_sleep_mask), .global_light_sleep(global_light_sleep),
      .global_deep_sleep(global_deep_sleep), .converter_ready(converter_ready),
      .common_mode_pin_ref(common_mode_pin_ref), .duty_cycle_corrector(duty_cycle_corrector),
      .diff_clock_select(diff_clock_select), .bit_clock_output_phase(bit_clock_output_phase),
      .noise_suppress(noise_suppress), .input_invert(input_invert), .channel_gain(channel_gain),
      .twos_complement_format(twos_complement_format), .msb_first(msb_first),
      .single_rate(single_rate), .single_rate_fall(single_rate_fall),
      .drive_bit_clock(drive_bit_clock), .drive_frame_clock(drive_frame_clock),
      .drive_data(drive_data));
   host_serial_model host (.clk_sys(clk_sys), .sen_n(sen_n), .sclk(sclk), .sdata(sdata),
      .sleep_pin(sleep_pin));

   assign snap = {channel_sleep_mask, global_light_sleep, global_deep_sleep, converter_ready,
      common_mode_pin_ref, duty_cycle_corrector, diff_clock_select, bit_clock_output_phase,
      noise_suppress, input_invert, channel_gain, twos_complement_format, msb_first, single_rate,
      single_rate_fall, drive_bit_clock, drive_frame_clock, drive_data};

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) if (sw_reset_pulse === 1'b1) pulses++;

   // Waking often ends before a write task returns, so cycles are counted alongside
   always @(posedge clk_sys) begin
      if ((global_light_sleep | global_deep_sleep) === 1'b1) wake_n <= 0;
      else if (converter_ready === 1'b0) wake_n <= wake_n + 1;
   end

   // Oldest note is matched against each result as it is handed over
   initial forever begin
      @(got_ev);
      checks++;
      if (got_val !== notes[0]) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got_val, notes[0]);
      end
      void'(notes.pop_front());
   end

   function automatic logic [76:0] expect_snap(input int mode);
      logic [31:0] g;
      g = {r2b[3:0], r2b[7:4], r2b[11:8], r2b[15:12], r2a[15:12], r2a[11:8], r2a[7:4], r2a[3:0]};
      return {(mode == 0) ? r0f[7:0] : 8'hff, mode == 1, mode == 2, mode == 0, r42[3], r42[2],
         r42[0], r42[6:5], r14[7:0], r24[7:0], g, r46[2], r46[3], r46[4], r46[13], r11[2:0],
         r11[6:4], r11[10:8]};
   endfunction

   task automatic note(input logic [76:0] e, input logic [76:0] g);
      notes.push_back(e);
      got_val = g;
      ->got_ev;
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      host.write_reg(a, d);
      case (a)
         8'h00: {r0f, r11, r14, r24, r2a, r2b, r42, r46} = '0;
         8'h0f: r0f = d;
         8'h11: r11 = d;
         8'h14: r14 = d;
         8'h24: r24 = d;
         8'h2a: r2a = d;
         8'h2b: r2b = d;
         8'h42: r42 = d;
         8'h46: r46 = d;
         default: ;
      endcase
      host.tick(4);
   endtask

   // Cycles from sleep release to converter ready, bounded both ways
   task automatic wake(input int lo, input int hi);
      int k;
      k = 0;
      while (converter_ready !== 1'b1 && k < 300) begin
         host.tick(1);
         k++;
      end
      note(77'd1, 77'(converter_ready === 1'b1 && wake_n >= lo && wake_n <= hi));
   endtask

   task automatic final_report();
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk_sys);
      n_fail++;
      final_report();
   end

   initial begin
      logic [7:0]  addrs[7] = '{8'h11, 8'h14, 8'h24, 8'h2a, 8'h2b, 8'h42, 8'h46};
      logic [15:0] keep[7]  = '{16'h0777, 16'h00ff, 16'h00ff, 16'hffff, 16'hffff, 16'h006d, 16'h201c};
      logic [15:0] force1[7] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h8200};
      logic [7:0]  chans;
      void'($urandom(32'hbe54e5d2));
      rst = 1'b1;
      {r0f, r11, r14, r24, r2a, r2b, r42, r46} = '0;
      repeat (12) @(posedge clk_sys);
      #1 rst = 1'b0;
      host.tick(2);
      note(expect_snap(0), snap);
      for (int i = 0; i < 7; i++) begin
         wr(addrs[i], (16'($urandom) & keep[i]) | force1[i]);
         note(expect_snap(0), snap);
      end
      chans = 8'($urandom);
      wr(8'h0f, {8'h00, chans});
      note(expect_snap(0), snap);
      // Clock has run far past the warm time, so light sleep wakes quickly
      wr(8'h0f, {8'h01, chans});
      note(expect_snap(1), snap);
      wr(8'h0f, {8'h00, chans});
      wake(LIGHT - 1, LIGHT + 2);
      wr(8'h0f, {8'h02, ~chans});
      note(expect_snap(2), snap);
      wr(8'h0f, {8'h00, ~chans});
      wake(DEEP - 1, DEEP + 2);
      host.set_pin(1'b1);
      host.tick(6);
      note(expect_snap(2), snap);
      host.set_pin(1'b0);
      wake(DEEP - 1, DEEP + 2);
      wr(8'h0f, {8'h04, chans});
      note(expect_snap(0), snap);
      host.set_pin(1'b1);
      host.tick(6);
      note(expect_snap(1), snap);
      host.set_pin(1'b0);
      wake(LIGHT - 1, LIGHT + 2);
      pulses = 0;
      wr(8'h00, 16'h0001);
      note(expect_snap(0), snap);
      note(77'd1, 77'(pulses));
      host.set_pin(1'b1);
      host.tick(6);
      note(expect_snap(2), snap);
      final_report();
   end
endmodule

`default_nettype wire
